/* File: shared/nvm_pkg.sv */
// Constants, types and register layout of the nonvolatile write controller
package nvm_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int EE_READ_NS = 300;
  localparam int FLASH_PROG_NS = 500000;
  localparam int EE_PROG_NS = 1000000;
  localparam int TO_SHORT_NS = 1600000;
  localparam int TO_MID_NS = 3200000;
  localparam int TO_LONG_NS = 12800000;
  // Least times round up, longest times round down
  localparam int EE_READ_CYC = (EE_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLASH_PROG_CYC = (FLASH_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EE_PROG_CYC = (EE_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TO_SHORT_CYC = TO_SHORT_NS / CLK_PERIOD_NS;
  localparam int TO_MID_CYC = TO_MID_NS / CLK_PERIOD_NS;
  localparam int TO_LONG_CYC = TO_LONG_NS / CLK_PERIOD_NS;
  localparam int TIMER_W = 18;
  localparam int WAIT_W = 3;
  localparam logic [WAIT_W-1:0] WAIT_LAST = 3'h1;
  // Register offsets and write keys
  localparam logic [7:0] SFR_NV_WRITE_ENABLE = 8'hc9;
  localparam logic [7:0] SFR_AUX_CONTROL_TWO = 8'hf7;
  localparam logic [7:0] KEY_FLASH = 8'h47;
  localparam logic [7:0] KEY_EEPROM = 8'he2;
  localparam logic [7:0] AUXILIARY_CONTROL_TWO_RESET = 8'h06;
  localparam int WE_FLASH_BIT = 7;
  localparam int WE_TIMEOUT_BIT = 6;
  localparam int WE_EEPROM_BIT = 5;
  localparam int AUXILIARY_CONTROL_TWO_TOSEL_LSB = 1;
  localparam int AUXILIARY_CONTROL_TWO_WDT_LSB = 6;
  // External data map
  localparam int EE_DEPTH = 128;
  localparam int EXTERNAL_SCRATCH_RAM_DEPTH = 256;
  localparam logic [7:0] EE_PAGE = 8'hee;
  localparam logic [7:0] EXTERNAL_SCRATCH_RAM_PAGE = 8'hff;
  localparam logic [15:0] FLASH_LAST = 16'h1ffe;
  typedef enum logic [1:0] {
    TO_OFF = 2'b00,
    TO_SHORT = 2'b01,
    TO_MID = 2'b10,
    TO_LONG = 2'b11
  } tosel_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b10
  } state_t;
endpackage

/* File: logic/write_timer.sv */
// Shared elapsed-time counter for flash and EEPROM programming
`timescale 1ns/1ps
`default_nettype none
module write_timer (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Counts while high, restarts from zero when low
  input wire logic i_run,
  output logic [nvm_pkg::TIMER_W-1:0] o_elapsed
);
  logic [nvm_pkg::TIMER_W-1:0] elapsed_q, elapsed_d;

  always_comb begin
    elapsed_d = '0;
    // Saturates so a stuck write never wraps back under a limit
    if (i_run && (elapsed_q != '1)) begin
      elapsed_d = elapsed_q + nvm_pkg::TIMER_W'(1);
    end else if (i_run) begin
      elapsed_d = elapsed_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      elapsed_q <= '0;
    end else begin
      elapsed_q <= elapsed_d;
    end
  end

  assign o_elapsed = elapsed_q;
endmodule // write_timer
`default_nettype wire

/* File: logic/eeprom_write_controller.sv */
// External data decoder with EEPROM, scratch RAM and guarded flash writes
`timescale 1ns/1ps
`default_nettype none
module eeprom_write_controller #(
  parameter int FLASH_PROG_CYC = nvm_pkg::FLASH_PROG_CYC,
  parameter int EE_PROG_CYC = nvm_pkg::EE_PROG_CYC,
  parameter int TO_SHORT_CYC = nvm_pkg::TO_SHORT_CYC,
  parameter int TO_MID_CYC = nvm_pkg::TO_MID_CYC,
  parameter int TO_LONG_CYC = nvm_pkg::TO_LONG_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Special function register port
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  // External data moves from the core
  input wire logic i_xdata_rd,
  input wire logic i_xdata_wr,
  input wire logic [15:0] i_xdata_addr,
  input wire logic [7:0] i_xdata_wdata,
  output logic [7:0] o_xdata_rdata,
  output logic o_xdata_ack,
  output logic o_cpu_stall,
  // Nonvolatile array
  input wire logic i_nv_ok,
  output logic o_flash_wr,
  output logic [15:0] o_flash_addr,
  output logic [7:0] o_flash_wdata,
  // Watchdog reset field
  output logic [1:0] o_watchdog_reset_control
);
  localparam int TW = nvm_pkg::TIMER_W;
  localparam int WW = nvm_pkg::WAIT_W;

  nvm_pkg::state_t state_q, state_d;
  logic [WW-1:0] wait_q, wait_d;
  logic flash_we_q, flash_we_d, ee_we_q, ee_we_d;
  logic to_flag_q, to_flag_d, to_src_ee_q, to_src_ee_d;
  logic [7:0] auxiliary_control_two_q, auxiliary_control_two_d, sfr_rdata_q, sfr_rdata_d;
  logic [7:0] xrdata_q, xrdata_d;
  logic ack_q, ack_d, stall_q, stall_d;
  logic fwr_q, fwr_d, is_ee_q, is_ee_d;
  logic [15:0] faddr_q, faddr_d;
  logic [7:0] wdata_q, wdata_d;
  logic [6:0] ee_idx_q, ee_idx_d;
  logic [7:0] ee_mem_q [nvm_pkg::EE_DEPTH];
  logic [7:0] external_scratch_ram_q [nvm_pkg::EXTERNAL_SCRATCH_RAM_DEPTH];
  logic [TW-1:0] elapsed, to_limit;
  logic ee_hit, ee_even, external_scratch_ram_hit, flash_hit, take_rd, take_wr;
  logic prog_done, expire, ee_commit, external_scratch_ram_commit, to_clr;
  nvm_pkg::tosel_t tosel;

  ////////////////////////////////////////////////////////////////////////////
  // Decode and the shared timer

  assign ee_hit = i_xdata_addr[15:8] == nvm_pkg::EE_PAGE;
  assign ee_even = ee_hit && !i_xdata_addr[0];
  assign external_scratch_ram_hit = i_xdata_addr[15:8] == nvm_pkg::EXTERNAL_SCRATCH_RAM_PAGE;
  assign flash_hit = i_xdata_addr <= nvm_pkg::FLASH_LAST;
  // Only the data-move port reaches these stores
  assign take_rd = (state_q == nvm_pkg::ST_IDLE) && i_xdata_rd;
  assign take_wr = (state_q == nvm_pkg::ST_IDLE) && i_xdata_wr && !i_xdata_rd;
  assign tosel = nvm_pkg::tosel_t'(auxiliary_control_two_q[nvm_pkg::AUXILIARY_CONTROL_TWO_TOSEL_LSB +: 2]);

  write_timer u_timer (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_run(state_q == nvm_pkg::ST_WRITE),
    .o_elapsed(elapsed)
  );

  always_comb begin
    case (tosel)
      nvm_pkg::TO_SHORT: to_limit = TW'(TO_SHORT_CYC - 1);
      nvm_pkg::TO_MID: to_limit = TW'(TO_MID_CYC - 1);
      nvm_pkg::TO_LONG: to_limit = TW'(TO_LONG_CYC - 1);
      default: to_limit = '1;
    endcase
  end

  // Program time ends only when the array also reports success
  assign prog_done = (state_q == nvm_pkg::ST_WRITE) && i_nv_ok &&
    (elapsed >= (is_ee_q ? TW'(EE_PROG_CYC - 1) : TW'(FLASH_PROG_CYC - 1)));
  assign expire = (state_q == nvm_pkg::ST_WRITE) && !prog_done &&
    (tosel != nvm_pkg::TO_OFF) && (elapsed >= to_limit);
  assign ee_commit = prog_done && is_ee_q;
  assign external_scratch_ram_commit = take_wr && external_scratch_ram_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer and registers

  always_comb begin
    state_d = state_q;
    wait_d = wait_q;
    flash_we_d = flash_we_q;
    ee_we_d = ee_we_q;
    auxiliary_control_two_d = auxiliary_control_two_q;
    xrdata_d = xrdata_q;
    ack_d = 1'b0;
    stall_d = stall_q;
    fwr_d = 1'b0;
    is_ee_d = is_ee_q;
    faddr_d = faddr_q;
    wdata_d = wdata_q;
    ee_idx_d = ee_idx_q;
    to_src_ee_d = to_src_ee_q;
    if (i_sfr_wr && (i_sfr_addr == nvm_pkg::SFR_NV_WRITE_ENABLE)) begin
      flash_we_d = i_sfr_wdata == nvm_pkg::KEY_FLASH;
      ee_we_d = i_sfr_wdata == nvm_pkg::KEY_EEPROM;
    end
    if (i_sfr_wr && (i_sfr_addr == nvm_pkg::SFR_AUX_CONTROL_TWO)) begin
      auxiliary_control_two_d = i_sfr_wdata;
    end
    case (state_q)
      nvm_pkg::ST_IDLE: begin
        if (take_rd && ee_hit) begin
          // EEPROM load waits out the array access time; odd reads give zero
          xrdata_d = ee_even ? ee_mem_q[i_xdata_addr[7:1]] : 8'h00;
          wait_d = WW'(nvm_pkg::EE_READ_CYC - 1);
          stall_d = 1'b1;
          state_d = nvm_pkg::ST_READ;
        end else if (take_rd) begin
          xrdata_d = external_scratch_ram_hit ? external_scratch_ram_q[i_xdata_addr[7:0]] : 8'h00;
          ack_d = 1'b1;
        end else if (take_wr && ee_even && ee_we_q) begin
          is_ee_d = 1'b1;
          ee_idx_d = i_xdata_addr[7:1];
          wdata_d = i_xdata_wdata;
          stall_d = 1'b1;
          state_d = nvm_pkg::ST_WRITE;
        end else if (take_wr && flash_hit && flash_we_q) begin
          is_ee_d = 1'b0;
          faddr_d = i_xdata_addr;
          wdata_d = i_xdata_wdata;
          fwr_d = 1'b1;
          stall_d = 1'b1;
          state_d = nvm_pkg::ST_WRITE;
        end else if (take_wr) begin
          ack_d = 1'b1;
        end
      end
      nvm_pkg::ST_READ: begin
        wait_d = wait_q - WW'(1);
        if (wait_q == nvm_pkg::WAIT_LAST) begin
          ack_d = 1'b1;
          stall_d = 1'b0;
          state_d = nvm_pkg::ST_IDLE;
        end
      end
      nvm_pkg::ST_WRITE: begin
        // Only the core waits; timers and interrupts run on elsewhere
        if (prog_done || expire) begin
          ack_d = 1'b1;
          stall_d = 1'b0;
          state_d = nvm_pkg::ST_IDLE;
        end
        if (expire) begin
          to_src_ee_d = is_ee_q;
        end
      end
      default: begin
        stall_d = 1'b0;
        state_d = nvm_pkg::ST_IDLE;
      end
    endcase
    // Timeout flag follows the enable of the write that failed; a set wins
    to_clr = to_src_ee_q ? !ee_we_d : !flash_we_d;
    to_flag_d = expire || (to_flag_q && !to_clr);
    sfr_rdata_d = 8'h00;
    if (i_sfr_addr == nvm_pkg::SFR_NV_WRITE_ENABLE) begin
      sfr_rdata_d[nvm_pkg::WE_FLASH_BIT] = flash_we_q;
      sfr_rdata_d[nvm_pkg::WE_TIMEOUT_BIT] = to_flag_q;
      sfr_rdata_d[nvm_pkg::WE_EEPROM_BIT] = ee_we_q;
    end else if (i_sfr_addr == nvm_pkg::SFR_AUX_CONTROL_TWO) begin
      sfr_rdata_d = auxiliary_control_two_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_q <= nvm_pkg::ST_IDLE;
      wait_q <= '0;
      flash_we_q <= 1'b0;
      ee_we_q <= 1'b0;
      to_flag_q <= 1'b0;
      to_src_ee_q <= 1'b0;
      auxiliary_control_two_q <= nvm_pkg::AUXILIARY_CONTROL_TWO_RESET;
      sfr_rdata_q <= 8'h00;
      xrdata_q <= 8'h00;
      ack_q <= 1'b0;
      stall_q <= 1'b0;
      fwr_q <= 1'b0;
      is_ee_q <= 1'b0;
      faddr_q <= 16'h0000;
      wdata_q <= 8'h00;
      ee_idx_q <= 7'h00;
    end else begin
      state_q <= state_d;
      wait_q <= wait_d;
      flash_we_q <= flash_we_d;
      ee_we_q <= ee_we_d;
      to_flag_q <= to_flag_d;
      to_src_ee_q <= to_src_ee_d;
      auxiliary_control_two_q <= auxiliary_control_two_d;
      sfr_rdata_q <= sfr_rdata_d;
      xrdata_q <= xrdata_d;
      ack_q <= ack_d;
      stall_q <= stall_d;
      fwr_q <= fwr_d;
      is_ee_q <= is_ee_d;
      faddr_q <= faddr_d;
      wdata_q <= wdata_d;
      ee_idx_q <= ee_idx_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Storage arrays, contents survive reset

  always_ff @(posedge i_clk) begin
    if (ee_commit) begin
      ee_mem_q[ee_idx_q] <= wdata_q;
    end
    if (external_scratch_ram_commit) begin
      external_scratch_ram_q[i_xdata_addr[7:0]] <= i_xdata_wdata;
    end
  end

  assign o_sfr_rdata = sfr_rdata_q;
  assign o_xdata_rdata = xrdata_q;
  assign o_xdata_ack = ack_q;
  assign o_cpu_stall = stall_q;
  assign o_flash_wr = fwr_q;
  assign o_flash_addr = faddr_q;
  assign o_flash_wdata = wdata_q;
  assign o_watchdog_reset_control = auxiliary_control_two_q[nvm_pkg::AUXILIARY_CONTROL_TWO_WDT_LSB +: 2];

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  logic sfr_we_hit;
  assign sfr_we_hit = i_sfr_wr && (i_sfr_addr == nvm_pkg::SFR_NV_WRITE_ENABLE);

  sequence s_ee_read_wait;
    (o_cpu_stall && !o_xdata_ack) [*5] ##1 (o_xdata_ack && !o_cpu_stall);
  endsequence
  sequence s_ee_prog_stall;
    (o_cpu_stall && !o_xdata_ack) [*8];
  endsequence

  property p_key_flash;
    sfr_we_hit && (i_sfr_wdata == nvm_pkg::KEY_FLASH) |=> flash_we_q && !ee_we_q;
  endproperty
  a_key_flash: assert property (p_key_flash) else $error("flash key not taken");
  property p_key_ee;
    sfr_we_hit && (i_sfr_wdata == nvm_pkg::KEY_EEPROM) |=> ee_we_q && !flash_we_q;
  endproperty
  a_key_ee: assert property (p_key_ee) else $error("eeprom key not taken");
  property p_key_other;
    sfr_we_hit && (i_sfr_wdata != nvm_pkg::KEY_FLASH) && (i_sfr_wdata != nvm_pkg::KEY_EEPROM)
      |=> !flash_we_q && !ee_we_q;
  endproperty
  a_key_other: assert property (p_key_other) else $error("enables not cleared");
  property p_ee_readback;
    (i_sfr_addr == nvm_pkg::SFR_NV_WRITE_ENABLE)
      |=> o_sfr_rdata[nvm_pkg::WE_EEPROM_BIT] == $past(ee_we_q);
  endproperty
  a_ee_readback: assert property (p_ee_readback) else $error("bit 5 wrong");
  property p_ee_read_time;
    take_rd && ee_hit |=> s_ee_read_wait;
  endproperty
  a_ee_read_time: assert property (p_ee_read_time) else $error("eeprom read timing");
  property p_ee_write_stall;
    take_wr && ee_even && ee_we_q |=> s_ee_prog_stall;
  endproperty
  a_ee_write_stall: assert property (p_ee_write_stall) else $error("no write stall");
  property p_locked_ee;
    take_wr && ee_hit && !ee_we_q |=> o_xdata_ack && !o_cpu_stall && !o_flash_wr;
  endproperty
  a_locked_ee: assert property (p_locked_ee) else $error("locked write stalled");
  property p_flash_guard;
    o_flash_wr |-> $past(flash_we_q) && o_cpu_stall;
  endproperty
  a_flash_guard: assert property (p_flash_guard) else $error("unguarded flash write");
  property p_timeout;
    expire |=> to_flag_q && o_xdata_ack && !o_cpu_stall;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout not flagged");
endmodule // eeprom_write_controller
`default_nettype wire

/* File: verification/nv_array_model.sv */
// Nonvolatile array stand-in: reports programming success and logs flash writes
`timescale 1ns/1ps
`default_nettype none
module nv_array_model (
  // Clock
  input wire logic i_clk,
  // Flash write request from the block
  input wire logic i_flash_wr,
  input wire logic [15:0] i_flash_addr,
  input wire logic [7:0] i_flash_wdata,
  // Failure request from the bench
  input wire logic i_fail,
  output logic o_nv_ok,
  output logic [15:0] o_last_addr,
  output logic [7:0] o_last_data,
  output int o_wr_count
);
  // A failing array never reports success, so the block must escape by timeout
  assign o_nv_ok = !i_fail;
  initial begin
    o_wr_count = 0;
    o_last_addr = 16'h0000;
    o_last_data = 8'h00;
  end
  always @(posedge i_clk) begin
    if (i_flash_wr === 1'b1) begin
      o_last_addr = i_flash_addr;
      o_last_data = i_flash_wdata;
      o_wr_count = o_wr_count + 1;
    end
  end
endmodule // nv_array_model
`default_nettype wire

/* File: verification/eeprom_write_controller_bench.sv */
// Self-checking bench for the external data and write-enable controller
`timescale 1ns/1ps
`default_nettype none
module eeprom_write_controller_bench;
  localparam int FPC = 20;
  localparam int EPC = 30;
  logic i_clk = 1'b0, i_sys_rst = 1'b1, i_sfr_wr = 1'b0;
  logic [7:0] i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00, o_sfr_rdata, o_xdata_rdata;
  logic i_xdata_rd = 1'b0, i_xdata_wr = 1'b0, o_xdata_ack, o_cpu_stall, i_nv_ok, o_flash_wr;
  logic [15:0] i_xdata_addr = 16'h0000, o_flash_addr, last_addr;
  logic [7:0] i_xdata_wdata = 8'h00, o_flash_wdata, last_data, q;
  logic [1:0] o_watchdog_reset_control;
  logic fail = 1'b0;
  int wr_count, n, st, miscompares = 0, checks_done = 0;
  logic [1:0] sel;
  always #25 i_clk = ~i_clk;
  eeprom_write_controller #(.FLASH_PROG_CYC(FPC), .EE_PROG_CYC(EPC), .TO_SHORT_CYC(40),
    .TO_MID_CYC(80), .TO_LONG_CYC(160)) dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_sfr_wr(i_sfr_wr), .i_sfr_addr(i_sfr_addr), .i_sfr_wdata(i_sfr_wdata),
    .o_sfr_rdata(o_sfr_rdata), .i_xdata_rd(i_xdata_rd), .i_xdata_wr(i_xdata_wr),
    .i_xdata_addr(i_xdata_addr), .i_xdata_wdata(i_xdata_wdata), .o_xdata_rdata(o_xdata_rdata),
    .o_xdata_ack(o_xdata_ack), .o_cpu_stall(o_cpu_stall), .i_nv_ok(i_nv_ok),
    .o_flash_wr(o_flash_wr), .o_flash_addr(o_flash_addr), .o_flash_wdata(o_flash_wdata),
    .o_watchdog_reset_control(o_watchdog_reset_control));
  nv_array_model array_u (.i_clk(i_clk), .i_flash_wr(o_flash_wr), .i_flash_addr(o_flash_addr),
    .i_flash_wdata(o_flash_wdata), .i_fail(fail), .o_nv_ok(i_nv_ok), .o_last_addr(last_addr),
    .o_last_data(last_data), .o_wr_count(wr_count));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_win(input string what, input int lo, input int hi, input int got);
    checks_done++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_sfr_wr <= 1'b1;
    i_sfr_addr <= a;
    i_sfr_wdata <= d;
    @(posedge i_clk);
    i_sfr_wr <= 1'b0;
  endtask
  task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_sfr_addr <= a;
    @(posedge i_clk);
    #1 chk("sfr read", {8'h00, exp}, {8'h00, o_sfr_rdata});
  endtask
  // One data move; n counts cycles from the taking edge to the ack
  task automatic xfer(input logic rd, input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_xdata_rd <= rd;
    i_xdata_wr <= !rd;
    i_xdata_addr <= a;
    i_xdata_wdata <= d;
    @(posedge i_clk);
    i_xdata_rd <= 1'b0;
    i_xdata_wr <= 1'b0;
    n = 0;
    st = 0;
    do begin
      if (n > 0) @(posedge i_clk);
      #1 n++;
      if (o_cpu_stall === 1'b1) st++;
    end while (o_xdata_ack !== 1'b1 && n < 400);
    q = o_xdata_rdata;
    if (n >= 400) chk("ack", 16'h0001, 16'h0000);
  endtask
  task automatic end_sim;
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge i_clk);
    miscompares++;
    end_sim;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    sfr_rd(8'hc9, 8'h00);
    sfr_rd(8'hf7, 8'h06);
    sfr_rd(8'h80, 8'h00);
    sfr_wr(8'hf7, 8'hc6);
    #1 chk("watchdog field", 16'h0003, {14'h0, o_watchdog_reset_control});
    sfr_rd(8'hf7, 8'hc6);
    sfr_wr(8'hf7, 8'h06);
    sfr_wr(8'hc9, 8'h47);
    sfr_rd(8'hc9, 8'h80);
    sfr_wr(8'hc9, 8'he2);
    sfr_rd(8'hc9, 8'h20);
    xfer(1'b0, 16'hee04, 8'ha5);
    chk_win("ee write cycles", EPC, EPC + 2, n);
    chk_win("ee write stall", EPC - 1, EPC + 1, st);
    xfer(1'b0, 16'hee05, 8'h11);
    chk_win("odd write cycles", 1, 1, n);
    xfer(1'b0, 16'heefe, 8'h3c);
    sfr_wr(8'hc9, 8'h5a);
    sfr_rd(8'hc9, 8'h00);
    xfer(1'b0, 16'hee04, 8'h77);
    chk_win("locked write cycles", 1, 1, n);
    chk_win("locked write stall", 0, 0, st);
    xfer(1'b1, 16'hee04, 8'h00);
    chk("ee byte 0x04", 16'h00a5, {8'h00, q});
    chk_win("ee read cycles", 6, 6, n);
    chk_win("ee read stall", 5, 5, st);
    xfer(1'b1, 16'heefe, 8'h00);
    chk("ee last byte", 16'h003c, {8'h00, q});
    xfer(1'b1, 16'hee05, 8'h00);
    chk("ee odd read", 16'h0000, {8'h00, q});
    xfer(1'b0, 16'hff00, 8'h5a);
    chk_win("scratch write cycles", 1, 1, n);
    xfer(1'b0, 16'hffff, 8'hc3);
    xfer(1'b1, 16'hff00, 8'h00);
    chk("scratch first", 16'h005a, {8'h00, q});
    chk_win("scratch read cycles", 1, 1, n);
    xfer(1'b1, 16'hffff, 8'h00);
    chk("scratch last", 16'h00c3, {8'h00, q});
    xfer(1'b0, 16'h1f00, 8'h5a);
    chk("locked flash", 16'h0000, wr_count[15:0]);
    sfr_wr(8'hc9, 8'h47);
    xfer(1'b0, 16'h1f00, 8'h5a);
    chk("flash writes", 16'h0001, wr_count[15:0]);
    chk("flash addr", 16'h1f00, last_addr);
    chk("flash data", 16'h005a, {8'h00, last_data});
    chk_win("flash cycles", FPC, FPC + 2, n);
    chk_win("flash stall", FPC - 1, FPC + 1, st);
    @(posedge i_clk) fail <= 1'b1;
    sfr_wr(8'hf7, 8'h02);
    xfer(1'b0, 16'h1f02, 8'h66);
    chk_win("flash timeout", 40, 42, n);
    sfr_rd(8'hc9, 8'hc0);
    sfr_wr(8'hc9, 8'h00);
    sfr_rd(8'hc9, 8'h00);
    for (int i = 1; i < 4; i++) begin
      sel = 2'(i);
      sfr_wr(8'hf7, {5'h00, sel, 1'b0});
      sfr_rd(8'hf7, {5'h00, sel, 1'b0});
      sfr_wr(8'hc9, 8'he2);
      xfer(1'b0, 16'hee04, 8'h99);
      chk_win("ee timeout", 40 << (i == 3 ? 2 : i - 1), (40 << (i == 3 ? 2 : i - 1)) + 2, n);
      sfr_rd(8'hc9, 8'h60);
      sfr_wr(8'hc9, 8'h00);
      sfr_rd(8'hc9, 8'h00);
    end
    @(posedge i_clk) fail <= 1'b0;
    sfr_wr(8'hf7, 8'h00);
    sfr_rd(8'hf7, 8'h00);
    xfer(1'b1, 16'hee04, 8'h00);
    chk("ee after timeouts", 16'h00a5, {8'h00, q});
    sfr_wr(8'hc9, 8'he2);
    xfer(1'b0, 16'hee06, 8'h42);
    chk_win("ee write timeout off", EPC, EPC + 2, n);
    xfer(1'b1, 16'hee06, 8'h00);
    chk("ee byte 0x06", 16'h0042, {8'h00, q});
    end_sim;
  end
endmodule // eeprom_write_controller_bench
`default_nettype wire
